// ### hdl/serial_port_four_mode.sv
// Overview of operation
// - In UART modes transmit and receive run at once; new byte overwrites an unread one.
// - Data buffer writes load transmit register; reads return separate receive register.
// - Shift mode moves eight bits LSB first on rxd, shift clock on txd.
// - Shift mode bit rate is half the system clock.
// - 8-bit UART frame: low start, eight data LSB first, high stop.
// - 8-bit UART reception stores the stop bit as received ninth bit.
// - 8-bit UART rate comes from timer 1 overflow events.
// - 9-bit frame adds transmit ninth bit after data, then stop.
// - 9-bit reception stores ninth bit; stop bit not used for acceptance.
// - Fixed 9-bit mode runs at clock/32 or clock/16.
// - Variable 9-bit mode equals fixed one but timed by timer 1.
// - A data buffer write with byte 0 strobed starts a transmission in every mode.
// - Shift mode receives when receive flag is clear, receive enabled and transmitter idle.
// - UART modes receive on a start bit only while receive enabled.
// - With filter set, 9-bit frames flag only when ninth bit is one.
// - Filter bit is ignored in shift mode.
// - With filter set, 8-bit frames flag only with a valid stop.
// - Control register layout bit 7 to 0, resets to zero.
// - Bad stop sets framing error; only software clears it.
// - Mode bits 00 shift, 01 UART8, 10 fixed UART9, 11 variable UART9.
`timescale 1ns/10ps
module serial_port_four_mode
#(
    parameter int ADDR_WIDTH = serial_port_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // AXI4-Lite write address
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Rate sources
    input wire logic timer1_overflow,
    input wire logic rate_double,
    // Line
    input wire logic rxd_in,
    output serial_port_pkg::line_out_s line_out,
    // Serial interrupt request
    output logic serial_irq
);
    import serial_port_pkg::*;

    // Refused at elaboration: the decoder needs a full byte of address
    if (ADDR_WIDTH < 8)
    begin : bad_width
        $error("ADDR_WIDTH must be at least 8");
    end

    function automatic reg_sel_e decode(input logic [ADDR_WIDTH-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr[ADDR_WIDTH-1:8] == '0)
        begin
            if (addr[7:2] == CONTROL_OFFSET[7:2])
            begin
                sel = SEL_CONTROL;
            end
            else if (addr[7:2] == DATA_OFFSET[7:2])
            begin
                sel = SEL_DATA;
            end
            else if (addr[7:2] == AUX_OFFSET[7:2])
            begin
                sel = SEL_AUX;
            end
        end
        return sel;
    endfunction

    serial_control_s control;
    logic framing_error;
    logic framing_access_select;
    logic [7:0] receive_buffer;
    mode_e mode;
    assign mode = mode_e'({control.mode_bit_zero, control.mode_bit_one});

    // Write channel capture; address and data may come in either order
    logic aw_held;
    logic w_held;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire;
    reg_sel_e wr_sel;
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    assign wr_sel = decode(aw_addr);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end
        else if (s_axi_awvalid && !aw_held)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (wr_fire)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end
        else if (s_axi_wvalid && !w_held)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (wr_fire)
        begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel; reads have no side effects
    reg_sel_e rd_sel;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_sel = decode(s_axi_araddr);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            unique case (rd_sel)
                SEL_CONTROL: s_axi_rdata <= {24'h000000,
                    framing_access_select ? framing_error : control.mode_bit_zero,
                    control[CONTROL_TOP_BIT-1:0]};
                SEL_DATA: s_axi_rdata <= {24'h000000, receive_buffer};
                SEL_AUX: s_axi_rdata <= {31'h00000000, framing_access_select};
                SEL_NONE: s_axi_rdata <= '0;
            endcase
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    logic tx_start;
    logic ctl_write;
    assign tx_start = wr_fire && (wr_sel == SEL_DATA) && w_strb[0];
    assign ctl_write = wr_fire && (wr_sel == SEL_CONTROL) && w_strb[0];

    // Input filter: change accepted once second and third stages agree
    logic [2:0] rxd_sync;
    logic rxd_level;
    logic rxd_prev;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rxd_sync <= 3'h7;
            rxd_level <= 1'b1;
            rxd_prev <= 1'b1;
        end
        else
        begin
            rxd_sync <= {rxd_sync[1:0], rxd_in};
            if (rxd_sync[1] == rxd_sync[2])
            begin
                rxd_level <= rxd_sync[2];
            end
            rxd_prev <= rxd_level;
        end
    end

    // Oversample tick: 9-bit fixed from the clock, others from timer 1
    logic rate_base;
    logic rate_toggle;
    logic sample_tick;
    assign rate_base = (mode == MODE_UART9_FIXED) ? 1'b1 : timer1_overflow;
    assign sample_tick = rate_base && (rate_double || rate_toggle);
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rate_toggle <= 1'b0;
        end
        else if (rate_base)
        begin
            rate_toggle <= !rate_toggle;
        end
    end

    // Transmitter
    logic tx_busy;
    logic tx_phase;
    logic [10:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_tick;
    logic tx_step;
    logic tx_done;
    assign tx_step = (mode == MODE_SHIFT) ? tx_phase : (sample_tick && tx_tick == 4'(OVERSAMPLE - 1));
    assign tx_done = tx_busy && !tx_start && tx_step && (tx_bits == 4'h1);

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            tx_busy <= 1'b0;
            tx_phase <= 1'b0;
            tx_shift <= '1;
            tx_bits <= '0;
            tx_tick <= '0;
        end
        else if (tx_start)
        begin
            tx_busy <= 1'b1;
            tx_phase <= 1'b0;
            tx_tick <= '0;
            unique case (mode)
                MODE_SHIFT:
                begin
                    tx_shift <= {3'h7, w_data[7:0]};
                    tx_bits <= SHIFT_BITS;
                end
                MODE_UART8:
                begin
                    tx_shift <= {2'h3, w_data[7:0], 1'b0};
                    tx_bits <= UART8_BITS;
                end
                MODE_UART9_FIXED, MODE_UART9_VAR:
                begin
                    tx_shift <= {1'b1, control.transmit_ninth_bit, w_data[7:0], 1'b0};
                    tx_bits <= UART9_BITS;
                end
            endcase
        end
        else if (tx_busy)
        begin
            if (mode == MODE_SHIFT)
            begin
                tx_phase <= !tx_phase;
            end
            else if (sample_tick)
            begin
                tx_tick <= tx_tick + 4'h1;
            end
            if (tx_step)
            begin
                tx_shift <= {1'b1, tx_shift[10:1]};
                tx_bits <= tx_bits - 4'h1;
                if (tx_bits == 4'h1)
                begin
                    tx_busy <= 1'b0;
                end
            end
        end
    end

    // Receiver
    logic rx_busy;
    logic rx_phase;
    logic [9:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_tick;
    logic rx_m0_start;
    logic rx_async_start;
    logic rx_sample;
    logic rx_last;
    logic rx_done;
    logic rx_accept;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic rx_bad_stop;
    logic nine_bit;
    assign nine_bit = (mode == MODE_UART9_FIXED) || (mode == MODE_UART9_VAR);
    assign rx_m0_start = (mode == MODE_SHIFT) && !rx_busy && !tx_busy && !tx_start
        && control.receive_enable && !control.receive_complete_flag;
    assign rx_async_start = (mode != MODE_SHIFT) && !rx_busy && control.receive_enable
        && rxd_prev && !rxd_level;
    assign rx_sample = (mode == MODE_SHIFT) ? rx_phase
        : (sample_tick && rx_tick == ((rx_bits == 4'h0) ? 4'(SAMPLE_POINT - 1)
        : 4'(OVERSAMPLE - 1)));
    assign rx_last = (mode == MODE_SHIFT) ? (rx_bits == SHIFT_BITS - 4'h1)
        : (rx_bits == (nine_bit ? UART9_BITS : UART8_BITS) - 4'h1);
    // Shift mode aborts a reception if software starts a transmit
    assign rx_done = rx_busy && rx_sample && rx_last && !(mode == MODE_SHIFT && tx_start);

    always_comb
    begin
        rx_bad_stop = 1'b0;
        rx_ninth = control.received_ninth_bit;
        rx_data = {rxd_level, rx_shift[9:3]};
        rx_accept = 1'b1;
        if (mode == MODE_UART8)
        begin
            rx_data = rx_shift[9:2];
            rx_ninth = rxd_level;
            rx_bad_stop = !rxd_level;
            rx_accept = !control.multiprocessor_filter || rxd_level;
        end
        else if (nine_bit)
        begin
            rx_data = rx_shift[8:1];
            rx_ninth = rx_shift[9];
            rx_bad_stop = !rxd_level;
            rx_accept = !control.multiprocessor_filter || rx_shift[9];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rx_busy <= 1'b0;
            rx_phase <= 1'b0;
            rx_shift <= '0;
            rx_bits <= '0;
            rx_tick <= '0;
        end
        else if (rx_m0_start)
        begin
            rx_busy <= 1'b1;
            rx_phase <= 1'b0;
            rx_bits <= '0;
        end
        else if (rx_async_start)
        begin
            rx_busy <= 1'b1;
            rx_tick <= '0;
            rx_bits <= '0;
        end
        else if (rx_busy)
        begin
            if (mode == MODE_SHIFT)
            begin
                rx_phase <= !rx_phase;
                if (tx_start)
                begin
                    rx_busy <= 1'b0;
                end
            end
            else if (sample_tick)
            begin
                rx_tick <= rx_sample ? 4'h0 : rx_tick + 4'h1;
            end
            if (rx_sample)
            begin
                if (mode != MODE_SHIFT && rx_bits == 4'h0 && rxd_level)
                begin
                    rx_busy <= 1'b0;
                end
                else
                begin
                    if (mode == MODE_SHIFT || rx_bits != 4'h0)
                    begin
                        rx_shift <= {rxd_level, rx_shift[9:1]};
                    end
                    rx_bits <= rx_bits + 4'h1;
                    if (rx_last)
                    begin
                        rx_busy <= 1'b0;
                    end
                end
            end
        end
    end

    // Receive buffer overwritten even when unread
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            receive_buffer <= DATA_RESET;
        end
        else if (rx_done && rx_accept)
        begin
            receive_buffer <= rx_data;
        end
    end

    // Control register; hardware set wins over a software clear
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            control <= serial_control_s'(CONTROL_RESET);
            framing_error <= 1'b0;
        end
        else
        begin
            if (ctl_write)
            begin
                control[CONTROL_TOP_BIT-1:3] <= w_data[CONTROL_TOP_BIT-1:3];
                if (!framing_access_select)
                begin
                    control.mode_bit_zero <= w_data[CONTROL_TOP_BIT];
                end
            end
            framing_error <= (rx_done && rx_bad_stop)
                || ((ctl_write && framing_access_select) ? w_data[CONTROL_TOP_BIT]
                : framing_error);
            control.received_ninth_bit <= (rx_done && rx_accept) ? rx_ninth
                : (ctl_write ? w_data[2] : control.received_ninth_bit);
            control.transmit_complete_flag <= tx_done
                || (ctl_write ? w_data[1] : control.transmit_complete_flag);
            control.receive_complete_flag <= (rx_done && rx_accept)
                || (ctl_write ? w_data[0] : control.receive_complete_flag);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            framing_access_select <= AUX_RESET;
        end
        else if (wr_fire && wr_sel == SEL_AUX && w_strb[0])
        begin
            framing_access_select <= w_data[AUX_ACCESS_BIT];
        end
    end

    assign serial_irq = control.transmit_complete_flag || control.receive_complete_flag;

    // Line drive: shift mode clock low in first half of each bit
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            line_out <= '{rxd_out: 1'b1, rxd_oe: 1'b0, txd_out: 1'b1};
        end
        else
        begin
            line_out.rxd_oe <= (mode == MODE_SHIFT) && (tx_busy || tx_start) && !tx_done;
            line_out.rxd_out <= tx_start ? w_data[0] : (tx_step ? tx_shift[1] : tx_shift[0]);
            if (mode == MODE_SHIFT)
            begin
                line_out.txd_out <= !(((tx_busy && !tx_done) || tx_start) ? (tx_start || tx_phase)
                    : ((rx_busy && !rx_done) || rx_m0_start) ? (rx_m0_start || rx_phase)
                    : 1'b0);
            end
            else
            begin
                line_out.txd_out <= tx_start ? 1'b0
                    : (tx_busy ? (tx_step ? tx_shift[1] : tx_shift[0]) : 1'b1);
            end
        end
    end

endmodule

// ### hdl/serial_port_pkg.sv
package serial_port_pkg;

    // Register map, byte addresses, one aligned word each
    localparam int ADDR_W = 8;
    localparam logic [7:0] CONTROL_OFFSET = 8'h98;
    localparam logic [7:0] DATA_OFFSET = 8'h9C;
    localparam logic [7:0] AUX_OFFSET = 8'hA0;

    // Reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic AUX_RESET = 1'b0;

    // Auxiliary and control register field positions
    localparam int AUX_ACCESS_BIT = 0;
    localparam int CONTROL_TOP_BIT = 7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing: 20 MHz system clock, shift mode runs at half of it
    localparam int CLK_HZ = 20_000_000;
    localparam int SHIFT_RATE_DIVIDE = 2;
    localparam int SHIFT_HALF_CYCLES = SHIFT_RATE_DIVIDE / 2;
    localparam int OVERSAMPLE = 16;
    localparam int SAMPLE_POINT = OVERSAMPLE / 2;

    // Frame lengths in bits
    localparam logic [3:0] SHIFT_BITS = 4'h8;
    localparam logic [3:0] UART8_BITS = 4'hA;
    localparam logic [3:0] UART9_BITS = 4'hB;

    typedef enum logic [1:0] {MODE_SHIFT, MODE_UART8, MODE_UART9_FIXED, MODE_UART9_VAR} mode_e;

    typedef enum logic [1:0] {SEL_CONTROL, SEL_DATA, SEL_AUX, SEL_NONE} reg_sel_e;

    typedef struct packed {
        logic mode_bit_zero;
        logic mode_bit_one;
        logic multiprocessor_filter;
        logic receive_enable;
        logic transmit_ninth_bit;
        logic received_ninth_bit;
        logic transmit_complete_flag;
        logic receive_complete_flag;
    } serial_control_s;

    typedef struct packed {
        logic rxd_out;
        logic rxd_oe;
        logic txd_out;
    } line_out_s;

endpackage

// ### tb/remote_uart.sv
`timescale 1ns/10ps
module remote_uart
(
    // Clock
    input wire logic sys_clk,
    // Line
    input wire logic txd,
    output logic rxd
);
    logic [10:0] got;
    int bit_clks = 16;
    // Pulled-up line idles high between frames
    initial rxd = 1'h1;
    task automatic send(input logic [10:0] bits, input int n);
        for (int i = 0; i < n; i++)
        begin
            rxd <= bits[i];
            repeat (bit_clks) @(posedge sys_clk);
        end
        rxd <= 1'h1;
        // Idle bit time, so back-to-back frames never drive rxd twice in one step
        repeat (bit_clks) @(posedge sys_clk);
    endtask
    // Samples mid bit, so a half-bit skew is tolerated
    task automatic grab(input int n);
        got = '1;
        @(negedge txd);
        repeat (bit_clks / 2) @(posedge sys_clk);
        for (int i = 0; i < n; i++)
        begin
            got[i] = txd;
            repeat (bit_clks) @(posedge sys_clk);
        end
    endtask
endmodule

// ### tb/serial_port_checker.sv
`timescale 1ns/10ps
module serial_port_checker
#(
    parameter int ADDR_WIDTH = serial_port_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Line and interrupt
    input serial_port_pkg::line_out_s line_out,
    input wire logic serial_irq
);
    import serial_port_pkg::*;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence shift_low;
        line_out.rxd_oe && !line_out.txd_out;
    endsequence
    a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response late");
    a_unmapped_read: assert property (rd_taken and (s_axi_araddr != CONTROL_OFFSET
        && s_axi_araddr != DATA_OFFSET && s_axi_araddr != AUX_OFFSET)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_byte_register: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_shift_clock: assert property (shift_low |=> line_out.txd_out)
        else $error("shift clock low too long");
    a_shift_data: assert property (shift_low |=> $stable(line_out.rxd_out))
        else $error("shift data moved mid bit");
    a_reset_idle: assert property (disable iff (1'h0) sys_rst
        |=> line_out.txd_out && !line_out.rxd_oe && !serial_irq)
        else $error("line not idle after reset");
endmodule

// ### tb/serial_port_four_mode_test.sv
`timescale 1ns/10ps
module serial_port_four_mode_test;
    import serial_port_pkg::*;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [7:0] awa = 8'h00;
    logic [7:0] ara = 8'h00;
    logic [31:0] wd = 32'h0;
    logic awv = 1'h0;
    logic wv = 1'h0;
    logic br = 1'h0;
    logic arv = 1'h0;
    logic rr = 1'h0;
    logic tov = 1'h0;
    logic rdbl = 1'h1;
    logic awrdy, wrdy, bv, arrdy, rv, irq, u_rxd;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata;
    logic [7:0] sh;
    line_out_s lo;
    wire rxd;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    assign rxd = lo.rxd_oe ? lo.rxd_out : u_rxd;
    always #25 sys_clk = !sys_clk;
    always @(posedge sys_clk) tov <= !tov;
    serial_port_four_mode DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .timer1_overflow(tov), .rate_double(rdbl), .rxd_in(rxd), .line_out(lo),
        .serial_irq(irq));
    remote_uart u (.sys_clk(sys_clk), .txd(lo.txd_out), .rxd(u_rxd));
    function automatic logic [10:0] fr(input logic [7:0] d, input logic n, input logic s);
        return {s, n, d, 1'h0};
    endfunction
    task automatic complete_run();
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        awa <= a;
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        br <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (awrdy)
                awv <= 1'h0;
            if (wrdy)
                wv <= 1'h0;
        end while (!bv);
        resp = bresp;
        br <= 1'h0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        ara <= a;
        arv <= 1'h1;
        rr <= 1'h1;
        do
        begin
            @(posedge sys_clk);
            if (arrdy)
                arv <= 1'h0;
        end while (!rv);
        resp = rresp;
        rr <= 1'h0;
        check(rdata, e);
    endtask
    // Hang guard, well above the few thousand cycles the frames need
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'h0;
        rdchk(CONTROL_OFFSET, 32'h0);
        rdchk(8'hA4, 32'h0);
        check(32'(resp), 32'(RESP_SLVERR));
        wr(8'hA4, 8'hFF);
        check(32'(resp), 32'(RESP_SLVERR));
        wr(CONTROL_OFFSET, 8'h98);
        fork
            u.send(fr(8'h3C, 1'h1, 1'h1), 11);
            wr(DATA_OFFSET, 8'hA5);
            u.grab(11);
        join
        check(32'(u.got), 32'(fr(8'hA5, 1'h1, 1'h1)));
        rdchk(DATA_OFFSET, 32'h3C);
        rdchk(CONTROL_OFFSET, 32'h9F);
        check(32'(irq), 32'h1);
        wr(CONTROL_OFFSET, 8'h98);
        u.send(fr(8'h11, 1'h0, 1'h1), 11);
        u.send(fr(8'h22, 1'h1, 1'h1), 11);
        rdchk(DATA_OFFSET, 32'h22);
        rdchk(CONTROL_OFFSET, 32'h9D);
        wr(CONTROL_OFFSET, 8'hB8);
        u.send(fr(8'h33, 1'h0, 1'h1), 11);
        rdchk(CONTROL_OFFSET, 32'hB8);
        check(32'(irq), 32'h0);
        u.send(fr(8'h44, 1'h1, 1'h1), 11);
        rdchk(DATA_OFFSET, 32'h44);
        wr(CONTROL_OFFSET, 8'h98);
        u.send(fr(8'h55, 1'h0, 1'h0), 11);
        wr(AUX_OFFSET, 8'h01);
        rdchk(DATA_OFFSET, 32'h55);
        rdchk(CONTROL_OFFSET, 32'h99);
        u.send(fr(8'h66, 1'h0, 1'h1), 11);
        rdchk(CONTROL_OFFSET, 32'h99);
        wr(AUX_OFFSET, 8'h00);
        rdbl <= 1'h0;
        u.bit_clks = 32;
        u.send(fr(8'h7E, 1'h0, 1'h1), 11);
        rdchk(DATA_OFFSET, 32'h7E);
        rdbl <= 1'h1;
        wr(CONTROL_OFFSET, 8'h40);
        u.send(fr(8'h77, 1'h1, 1'h1), 10);
        rdchk(CONTROL_OFFSET, 32'h40);
        wr(CONTROL_OFFSET, 8'h50);
        fork
            u.send(fr(8'hC3, 1'h1, 1'h1), 10);
            wr(DATA_OFFSET, 8'h5A);
            u.grab(10);
        join
        check(32'(u.got), 32'(fr(8'h5A, 1'h1, 1'h1)));
        rdchk(DATA_OFFSET, 32'hC3);
        rdchk(CONTROL_OFFSET, 32'h57);
        wr(CONTROL_OFFSET, 8'hD8);
        u.send(fr(8'h81, 1'h1, 1'h1), 11);
        rdchk(CONTROL_OFFSET, 32'hDD);
        wr(CONTROL_OFFSET, 8'h00);
        fork
            wr(DATA_OFFSET, 8'h96);
            for (int i = 0; i < 8; i++)
            begin
                @(posedge lo.txd_out);
                sh[i] = lo.rxd_out;
            end
        join
        check(32'(sh), 32'h96);
        complete_run();
    end
endmodule
bind serial_port_four_mode serial_port_checker #(.ADDR_WIDTH(ADDR_WIDTH)) chk (.sys_clk,
    .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_out, .serial_irq);
